// ---- rtl/bdp_pkg.sv ----
// Package for the four-port bidirectional digital I/O block.
// Assumes a single 125 MHz clock and a plain strobe register port.
package bdp_pkg;
	localparam int PORT_W = 8;
	localparam int NUM_PORTS = 4;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int FIFO_W = 8;
	localparam int FIFO_DEPTH = 8;
	// Register map in byte addresses, one 32-bit word every 4 bytes; per-port registers step by PORT_STRIDE.
	localparam logic [7:0] REG_DIR = 8'h00;
	localparam logic [7:0] REG_LEVEL = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_STREAM = 8'h0c;
	localparam logic [7:0] REG_FIFO_STAT = 8'h10;
	localparam logic [7:0] REG_PORT_BASE = 8'h40;
	localparam logic [7:0] PORT_STRIDE = 8'h20;
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_RISE_MASK = 8'h04;
	localparam logic [7:0] OFS_FALL_MASK = 8'h08;
	localparam logic [7:0] OFS_MATCH_REF = 8'h0c;
	localparam logic [7:0] OFS_MATCH_EN = 8'h10;
	localparam logic [7:0] OFS_RISE_STAT = 8'h14;
	localparam logic [7:0] OFS_FALL_STAT = 8'h18;
	// Reset values: all ports input, 3.3 V level.
	localparam logic [3:0] DIR_RESET = 4'h0;
	localparam logic LEVEL_RESET = 1'b0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// Streaming pace: a 10 kHz period at 125 MHz.
	localparam int CLK_MHZ = 125;
	localparam int STREAM_PERIOD_US = 100;
	localparam int STREAM_CYCLES = STREAM_PERIOD_US * CLK_MHZ;
	localparam int PACE_W = 16;
	// Rising and falling edge status of one port, carried together.
	typedef struct packed {
		logic [PORT_W-1:0] rise;
		logic [PORT_W-1:0] fall;
	} bdp_edge_t;
endpackage

// ---- rtl/bdp_fifo.sv ----
// Parameterised FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module bdp_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH):0] level
);
	localparam int AW = $clog2(DEPTH);
	// Storage array; the block keeps a handful of words, so flops are fine.
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;

	assign in_ready = (cnt_reg != DEPTH[AW:0]);
	assign out_valid = (cnt_reg != '0);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_reg[rd_reg];
	assign level = cnt_reg;

	// Pointers and fill count move together so full and empty stay honest.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end

	// Data array is written without reset; only written words are ever read.
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end
endmodule // bdp_fifo

// ---- rtl/bdp_port.sv ----
// Four 8-bit bidirectional digital ports with edge and pattern interrupts.
// Assumes pins are synchronous to sys_clk and a level shifter outside obeys level_5v.
`timescale 1ns/1ps
module bdp_port
	import bdp_pkg::*;
#(
	parameter bit HAS_MATCH = 1'b1,
	parameter bit ISOLATED = 1'b0,
	parameter int STREAM_CYC = bdp_pkg::STREAM_CYCLES
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [bdp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [bdp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [bdp_pkg::DATA_W-1:0] reg_rdata,
	input wire logic [bdp_pkg::PORT_W-1:0] port_a_in,
	output logic [bdp_pkg::PORT_W-1:0] port_a_out,
	output logic port_a_oe,
	input wire logic [bdp_pkg::PORT_W-1:0] port_b_in,
	output logic [bdp_pkg::PORT_W-1:0] port_b_out,
	output logic port_b_oe,
	input wire logic [bdp_pkg::PORT_W-1:0] port_c_in,
	output logic [bdp_pkg::PORT_W-1:0] port_c_out,
	output logic port_c_oe,
	input wire logic [bdp_pkg::PORT_W-1:0] port_d_in,
	output logic [bdp_pkg::PORT_W-1:0] port_d_out,
	output logic port_d_oe,
	output logic level_5v,
	output logic irq
);
	import bdp_pkg::*;

	// Streaming phases: idle, or moving one sample per pace tick.
	// Only one port streams at a time, so one state serves all four ports.
	typedef enum logic [1:0] {ST_IDLE, ST_IN, ST_OUT} bdp_stream_t;

	// Register copies of the per-port software settings.
	logic [NUM_PORTS-1:0] dir_reg; // One bit per port; 1 means output.
	logic level_reg; // 1 selects 5 V signalling.
	logic [PORT_W-1:0] out_reg [NUM_PORTS]; // Values driven when output.
	logic [PORT_W-1:0] rmask_reg [NUM_PORTS]; // Rising-edge masks.
	logic [PORT_W-1:0] fmask_reg [NUM_PORTS]; // Falling-edge masks.
	logic [PORT_W-1:0] mref_reg [NUM_PORTS]; // Match reference patterns.
	logic [NUM_PORTS-1:0] men_reg; // Match enables.
	bdp_edge_t estat_reg [NUM_PORTS]; // Latched edge status.
	logic [NUM_PORTS-1:0] mstat_reg; // Latched match flags.
	// Per-port event and clear terms, worked out afresh every cycle.
	logic [PORT_W-1:0] rise_ev [NUM_PORTS]; // Masked rising edges seen now.
	logic [PORT_W-1:0] fall_ev [NUM_PORTS]; // Masked falling edges seen now.
	logic [NUM_PORTS-1:0] mat_ev; // Pattern matches seen now.
	logic [PORT_W-1:0] rise_clr [NUM_PORTS]; // Rising status bits software clears.
	logic [PORT_W-1:0] fall_clr [NUM_PORTS]; // Falling status bits software clears.
	logic [NUM_PORTS-1:0] mat_clr; // Match flags software clears.
	logic [PORT_W-1:0] prev_reg [NUM_PORTS]; // Previous samples.
	logic [PORT_W-1:0] pin_in [NUM_PORTS]; // Pin values gathered.
	logic [NUM_PORTS-1:0] dir_eff; // Direction after variant forcing.
	logic [DATA_W-1:0] rdata_next;
	// Streaming state. The build sets the pace through STREAM_CYC, and the
	// FIFO absorbs the jitter of a host that polls or feeds it late. A host
	// slower than the pace loses input samples rather than stalling the pins.
	bdp_stream_t st_reg;
	logic [1:0] sport_reg; // Port streamed.
	logic [PACE_W-1:0] pace_reg;
	logic pace_tick;
	logic fin_valid;
	logic fin_ready;
	logic [FIFO_W-1:0] fin_data;
	logic fout_valid;
	logic fout_ready;
	logic [FIFO_W-1:0] fout_data;
	logic [$clog2(FIFO_DEPTH):0] flevel;
	logic stream_wr;
	logic stream_rd;

	// Register map, byte addresses on the plain strobe port:
	//   0x00 direction, one bit per port, a set bit drives the port.
	//   0x04 signalling level, bit 0 set selects 5 V for all pins.
	//   0x08 pattern-match flags, one per port, write one to clear.
	//   0x0c stream: while idle a write with bit 0 set starts on the port
	//        in bits 2:1; streaming out, a write queues a word; streaming
	//        in, a read returns {valid, head} and pops the head.
	//   0x10 stream status {room, state, level}; any write stops streaming.
	// Per-port window from 0x40, one 0x20 step per port:
	//   +0x00 data, +0x04 rising mask, +0x08 falling mask,
	//   +0x0c match reference, +0x10 match enable,
	//   +0x14 rising status and +0x18 falling status, both write one to clear.
	// Unmapped reads answer zero and unmapped writes are dropped.

	// Port index of an address in the per-port window, and its offset.
	// Addresses above the fourth port alias back onto the window; the
	// decode stays small and software never uses that range.
	function automatic logic [1:0] port_idx(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] d;
		d = a - REG_PORT_BASE;
		return d[6:5];
	endfunction
	function automatic logic [ADDR_W-1:0] port_ofs(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] d;
		d = a - REG_PORT_BASE;
		return {3'h0, d[4:0]};
	endfunction
	function automatic logic in_window(input logic [ADDR_W-1:0] a);
		return a >= REG_PORT_BASE;
	endfunction

	// Pins are taken as synchronous to sys_clk; field signals that are not
	// need a synchroniser outside this block, or edges may be double counted.
	assign pin_in[0] = port_a_in;
	assign pin_in[1] = port_b_in;
	assign pin_in[2] = port_c_in;
	assign pin_in[3] = port_d_in;

	// Isolated build pins a to input and b to output.
	// The direction register still stores what software wrote for a and b.
	always_comb begin
		dir_eff = dir_reg;
		if (ISOLATED) begin
			dir_eff[0] = 1'b0;
			dir_eff[1] = 1'b1;
		end
	end

	// Drivers are released for every input port.
	assign port_a_out = out_reg[0];
	assign port_b_out = out_reg[1];
	assign port_c_out = out_reg[2];
	assign port_d_out = out_reg[3];
	assign port_a_oe = dir_eff[0];
	assign port_b_oe = dir_eff[1];
	assign port_c_oe = dir_eff[2];
	assign port_d_oe = dir_eff[3];
	// One level select serves all four ports alike.
	assign level_5v = level_reg;

	assign stream_wr = reg_wr && reg_addr == REG_STREAM;
	assign stream_rd = reg_rd && reg_addr == REG_STREAM;

	// Global control: direction word and shared voltage level.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			dir_reg <= DIR_RESET;
			level_reg <= LEVEL_RESET;
		end else if (reg_wr && reg_addr == REG_DIR) begin
			dir_reg <= reg_wdata[NUM_PORTS-1:0];
		end else if (reg_wr && reg_addr == REG_LEVEL) begin
			level_reg <= reg_wdata[0];
		end
	end

	// Per-port settings; output data also loads from the stream FIFO.
	// Output data may be written while a port is input, so the first value
	// driven after a direction change is already the intended one.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				out_reg[i] <= BYTE_ZERO;
				rmask_reg[i] <= BYTE_ZERO;
				fmask_reg[i] <= BYTE_ZERO;
				mref_reg[i] <= BYTE_ZERO;
			end
			men_reg <= '0;
		end else begin
			if (reg_wr && in_window(reg_addr)) begin
				unique case (port_ofs(reg_addr))
					OFS_DATA: out_reg[port_idx(reg_addr)] <= reg_wdata[PORT_W-1:0];
					OFS_RISE_MASK: rmask_reg[port_idx(reg_addr)] <= reg_wdata[PORT_W-1:0];
					OFS_FALL_MASK: fmask_reg[port_idx(reg_addr)] <= reg_wdata[PORT_W-1:0];
					OFS_MATCH_REF: mref_reg[port_idx(reg_addr)] <= reg_wdata[PORT_W-1:0];
					OFS_MATCH_EN: men_reg[port_idx(reg_addr)] <= reg_wdata[0] & HAS_MATCH;
					default: begin
						// Status offsets are cleared in their own process.
					end
				endcase
			end
			// A streamed word lands on the output port at a pace tick when the FIFO holds one.
			if (st_reg == ST_OUT && pace_tick && fout_valid) begin
				out_reg[sport_reg] <= fout_data;
			end
		end
	end

	// Sample history for edge detection, one clock behind the pins.
	// Reset loads the live pins, so a high pin shows no false edge after it.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				prev_reg[i] <= pin_in[i];
			end
		end else begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				prev_reg[i] <= pin_in[i];
			end
		end
	end

	// Event and clear terms per port. Output ports raise nothing new, but
	// software may still clear whatever they latched while they were inputs.
	always_comb begin
		for (int i = 0; i < NUM_PORTS; i++) begin
			rise_ev[i] = pin_in[i] & ~prev_reg[i] & rmask_reg[i];
			fall_ev[i] = ~pin_in[i] & prev_reg[i] & fmask_reg[i];
			mat_ev[i] = HAS_MATCH && men_reg[i] && pin_in[i] == mref_reg[i];
			rise_clr[i] = BYTE_ZERO;
			fall_clr[i] = BYTE_ZERO;
			mat_clr[i] = reg_wr && reg_addr == REG_STATUS && reg_wdata[i];
			// Write-one-to-clear on the per-port status words.
			if (reg_wr && in_window(reg_addr) && port_idx(reg_addr) == i[1:0]) begin
				if (port_ofs(reg_addr) == OFS_RISE_STAT) begin
					rise_clr[i] = reg_wdata[PORT_W-1:0];
				end
				if (port_ofs(reg_addr) == OFS_FALL_STAT) begin
					fall_clr[i] = reg_wdata[PORT_W-1:0];
				end
			end
			if (dir_eff[i]) begin
				// Output ports raise nothing new.
				rise_ev[i] = BYTE_ZERO;
				fall_ev[i] = BYTE_ZERO;
				mat_ev[i] = 1'b0;
			end
		end
	end

	// Sticky event status. The set term is ORed after the clear, so an event
	// that meets a software clear in the same cycle is never lost.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				estat_reg[i] <= '0;
			end
			mstat_reg <= '0;
		end else begin
			for (int i = 0; i < NUM_PORTS; i++) begin
				estat_reg[i].rise <= (estat_reg[i].rise & ~rise_clr[i]) | rise_ev[i];
				estat_reg[i].fall <= (estat_reg[i].fall & ~fall_clr[i]) | fall_ev[i];
				mstat_reg[i] <= (mstat_reg[i] & ~mat_clr[i]) | mat_ev[i];
			end
		end
	end

	// Interrupt stays up while any status of an input port is set.
	// It is a plain OR of flops, so it cannot glitch on its own.
	always_comb begin
		irq = 1'b0;
		for (int i = 0; i < NUM_PORTS; i++) begin
			if (!dir_eff[i] && (|estat_reg[i].rise || |estat_reg[i].fall || mstat_reg[i])) begin
				irq = 1'b1;
			end
		end
	end

	// Pace timer: one tick per 10 kHz period while streaming.
	// It restarts from zero on every start, so the first tick comes one period late.
	always_ff @(posedge sys_clk) begin
		if (!nrst || st_reg == ST_IDLE || pace_reg == PACE_W'(STREAM_CYC - 1)) begin
			pace_reg <= '0;
		end else begin
			pace_reg <= pace_reg + 1'b1;
		end
	end
	assign pace_tick = (pace_reg == PACE_W'(STREAM_CYC - 1));

	// Stream control: bit 0 start, bits 2:1 port; direction picks the way.
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_reg <= ST_IDLE;
			sport_reg <= 2'h0;
		end else if (reg_wr && reg_addr == REG_FIFO_STAT) begin
			st_reg <= ST_IDLE;
		end else if (stream_wr && st_reg == ST_IDLE && reg_wdata[0]) begin
			sport_reg <= reg_wdata[2:1];
			st_reg <= dir_eff[reg_wdata[2:1]] ? ST_OUT : ST_IN;
		end
	end

	// One FIFO serves both ways: input samples fill it on ticks and software
	// drains it; in output mode software fills it and ticks drain it. A full
	// FIFO drops the input sample, since pins cannot be held back.
	// While idle the FIFO drains one word per cycle, so a new stream started eight or more
	// cycles after the stop has no words left over from the last one; unread samples are lost.
	always_comb begin
		fin_valid = 1'b0;
		fin_data = BYTE_ZERO;
		fout_ready = 1'b0;
		unique case (st_reg)
			ST_IN: begin
				fin_valid = pace_tick;
				fin_data = pin_in[sport_reg];
				fout_ready = stream_rd;
			end
			ST_OUT: begin
				fin_valid = stream_wr;
				fin_data = reg_wdata[PORT_W-1:0];
				fout_ready = pace_tick;
			end
			ST_IDLE: begin
				fout_ready = 1'b1;
			end
		endcase
	end

	// Eight words cover almost a millisecond of host latency at full pace.
	// Its level is exported so software can see how close it is to overrun.
	bdp_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.in_valid(fin_valid),
		.in_ready(fin_ready),
		.in_data(fin_data),
		.out_valid(fout_valid),
		.out_ready(fout_ready),
		.out_data(fout_data),
		.level(flevel)
	);

	// Read mux; unmapped addresses answer zero.
	// The stream word shows the stale head even when valid is low, so
	// software must test the valid bit before it trusts the data byte.
	always_comb begin
		rdata_next = '0;
		if (reg_addr == REG_DIR) begin
			rdata_next[NUM_PORTS-1:0] = dir_eff;
		end else if (reg_addr == REG_LEVEL) begin
			rdata_next[0] = level_reg;
		end else if (reg_addr == REG_STATUS) begin
			rdata_next[NUM_PORTS-1:0] = mstat_reg;
		end else if (reg_addr == REG_STREAM) begin
			rdata_next = {23'h0, fout_valid, fout_data};
		end else if (reg_addr == REG_FIFO_STAT) begin
			rdata_next = {24'h0, fin_ready, st_reg, 1'b0, flevel};
		end else if (in_window(reg_addr)) begin
			unique case (port_ofs(reg_addr))
				OFS_DATA: rdata_next[PORT_W-1:0] = dir_eff[port_idx(reg_addr)] ?
					out_reg[port_idx(reg_addr)] : pin_in[port_idx(reg_addr)];
				OFS_RISE_MASK: rdata_next[PORT_W-1:0] = rmask_reg[port_idx(reg_addr)];
				OFS_FALL_MASK: rdata_next[PORT_W-1:0] = fmask_reg[port_idx(reg_addr)];
				OFS_MATCH_REF: rdata_next[PORT_W-1:0] = mref_reg[port_idx(reg_addr)];
				OFS_MATCH_EN: rdata_next[0] = men_reg[port_idx(reg_addr)];
				OFS_RISE_STAT: rdata_next[PORT_W-1:0] = estat_reg[port_idx(reg_addr)].rise;
				OFS_FALL_STAT: rdata_next[PORT_W-1:0] = estat_reg[port_idx(reg_addr)].fall;
				default: rdata_next = '0;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge sys_clk) begin
		if (!nrst || !reg_rd) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= rdata_next;
		end
	end
endmodule // bdp_port

// ---- dv/bdp_port_assertions.sv ----
// Checker for the four-port digital I/O block.
// Sees only the block's ports and is bound to every instance below.
`timescale 1ns/1ps
module bdp_port_checker (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [7:0] port_a_in,
	input wire logic [7:0] port_a_out,
	input wire logic port_a_oe,
	input wire logic [7:0] port_b_in,
	input wire logic [7:0] port_b_out,
	input wire logic port_b_oe,
	input wire logic [7:0] port_c_in,
	input wire logic [7:0] port_c_out,
	input wire logic port_c_oe,
	input wire logic [7:0] port_d_in,
	input wire logic [7:0] port_d_out,
	input wire logic port_d_oe,
	input wire logic level_5v,
	input wire logic irq
);
	logic [31:0] pins_reg; // Previous pin sample, kept to see pin movement.
	wire logic [3:0] oes = {port_d_oe, port_c_oe, port_b_oe, port_a_oe};
	wire logic [31:0] pins = {port_d_in, port_c_in, port_b_in, port_a_in};
	// An interrupt may only follow a pin change or a register write.
	wire logic cause = (pins != pins_reg) || reg_wr;
	// Sample the pins every cycle; no reset needed for a history register.
	always_ff @(posedge sys_clk) begin
		pins_reg <= pins;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	sequence s_dir_wr;
		reg_wr && reg_addr == 8'h00;
	endsequence
	sequence s_rd_a;
		reg_rd && reg_addr == 8'h40 && port_a_oe;
	endsequence
	a_reset_quiet: assert property (disable iff (1'b0)
		!nrst |=> oes == 4'h0 && !level_5v && !irq) else $error("outputs live after reset");
	a_dir_to_oe: assert property (s_dir_wr |=> oes == $past(reg_wdata[3:0]))
		else $error("direction write not applied");
	a_oe_steady: assert property (!reg_wr |=> $stable(oes))
		else $error("direction moved without a write");
	a_level_set: assert property (reg_wr && reg_addr == 8'h04 |=>
		level_5v == $past(reg_wdata[0])) else $error("level select not applied");
	a_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	a_out_write: assert property (reg_wr && reg_addr == 8'h40 && port_a_oe |=>
		port_a_out == $past(reg_wdata[7:0])) else $error("output write not applied");
	a_read_back: assert property (s_rd_a |=> reg_rdata == {24'h0, $past(port_a_out)})
		else $error("output read back wrong");
	a_irq_cause: assert property ($rose(irq) |->
		$past(cause) || $past(cause, 2) || $past(cause, 3)) else $error("irq without cause");
	a_irq_hold: assert property (irq && !reg_wr |=> irq)
		else $error("irq dropped without a write");
endmodule // bdp_port_checker
bind bdp_port bdp_port_checker u_chk (
	.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
	.port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe(port_b_oe),
	.port_c_in(port_c_in), .port_c_out(port_c_out), .port_c_oe(port_c_oe),
	.port_d_in(port_d_in), .port_d_out(port_d_out), .port_d_oe(port_d_oe),
	.level_5v(level_5v), .irq(irq)
);

// ---- dv/bdp_field_model.sv ----
// Field wiring model for the four TTL ports.
// Assumes the bench sets what the field devices drive.
`timescale 1ns/1ps
module bdp_field_model (
	input wire logic [31:0] field_drv,
	input wire logic [31:0] dev_out,
	input wire logic [3:0] dev_oe,
	output logic [31:0] pin_lvl
);
	// While the block drives a port the field only listens, so the pin shows the block's value.
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			pin_lvl[p*8 +: 8] = dev_oe[p] ? dev_out[p*8 +: 8] : field_drv[p*8 +: 8];
		end
	end
endmodule // bdp_field_model

// ---- dv/bdp_port_tb.sv ----
// Self-checking bench for the four-port digital I/O block.
// Assumes the field model on the pins and the checker bound to the block.
`timescale 1ns/1ps
module bdp_port_tb;
	import bdp_pkg::*;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] field_drv = 32'h0;
	logic [31:0] reg_rdata;
	logic [31:0] pins;
	logic [31:0] rdv;
	logic level_5v;
	logic irq;
	wire [31:0] outs;
	wire [3:0] oes;
	int miscompares = 0;
	int n_compared = 0;
	always #4 sys_clk = ~sys_clk;
	// A short pace keeps the stream test brief.
	bdp_port #(.STREAM_CYC(4)) u_dut (
		.sys_clk(sys_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.port_a_in(pins[7:0]), .port_a_out(outs[7:0]), .port_a_oe(oes[0]),
		.port_b_in(pins[15:8]), .port_b_out(outs[15:8]), .port_b_oe(oes[1]),
		.port_c_in(pins[23:16]), .port_c_out(outs[23:16]), .port_c_oe(oes[2]),
		.port_d_in(pins[31:24]), .port_d_out(outs[31:24]), .port_d_oe(oes[3]),
		.level_5v(level_5v), .irq(irq)
	);
	bdp_field_model u_field (.field_drv(field_drv), .dev_out(outs), .dev_oe(oes), .pin_lvl(pins));
	function automatic logic [7:0] pa(input int n, input logic [7:0] o);
		return REG_PORT_BASE + PORT_STRIDE * n[7:0] + o;
	endfunction
	// One write cycle; the trailing delay lets the write land before callers look.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		#1;
	endtask
	// One read cycle; data are taken in the single cycle they stand.
	task automatic rd(input logic [7:0] a);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rdv = reg_rdata;
	endtask
	// Field change, then enough cycles for the edge status to latch.
	task automatic drv(input logic [31:0] v);
		@(posedge sys_clk);
		field_drv <= v;
		repeat (4) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wrap_up;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic t_reset;
		chk({oes, level_5v, irq}, 32'h0);
		chk(outs, 32'h0);
		rd(REG_DIR);
		chk(rdv, 32'h0);
	endtask
	task automatic t_dir;
		for (int n = 0; n < 4; n++) begin
			wr(REG_DIR, 32'h1 << n);
			chk({28'h0, oes}, 32'h1 << n);
		end
		wr(REG_LEVEL, 32'h1);
		chk({31'h0, level_5v}, 32'h1);
		wr(REG_LEVEL, 32'h0);
		chk({31'h0, level_5v}, 32'h0);
	endtask
	task automatic t_out;
		drv(32'h5a);
		wr(REG_DIR, 32'hf);
		for (int n = 0; n < 4; n++) begin
			wr(pa(n, OFS_DATA), 32'ha5 ^ n);
			chk({24'h0, outs[n*8 +: 8]}, 32'ha5 ^ n);
			rd(pa(n, OFS_DATA));
			chk(rdv, 32'ha5 ^ n);
		end
		rd(8'hfc);
		chk(rdv, 32'h0);
		wr(pa(0, OFS_RISE_MASK), 32'hff);
		wr(pa(0, OFS_DATA), 32'h5a);
		drv(32'h5a);
		chk({31'h0, irq}, 32'h0);
		wr(REG_DIR, 32'h0);
	endtask
	task automatic t_edge;
		wr(pa(2, OFS_RISE_STAT), 32'hff);
		wr(pa(2, OFS_FALL_STAT), 32'hff);
		wr(pa(2, OFS_RISE_MASK), 32'h04);
		wr(pa(2, OFS_FALL_MASK), 32'h80);
		drv(32'h0008005a);
		chk({31'h0, irq}, 32'h0);
		drv(32'h008c005a);
		chk({31'h0, irq}, 32'h1);
		rd(pa(2, OFS_RISE_STAT));
		chk(rdv, 32'h04);
		rd(pa(2, OFS_FALL_STAT));
		chk(rdv, 32'h0);
		chk({31'h0, irq}, 32'h1);
		wr(pa(2, OFS_RISE_STAT), 32'h04);
		chk({31'h0, irq}, 32'h0);
		drv(32'h000c005a);
		rd(pa(2, OFS_FALL_STAT));
		chk(rdv, 32'h80);
		wr(pa(2, OFS_FALL_STAT), 32'hff);
		wr(pa(2, OFS_RISE_MASK), 32'hff);
		drv(32'h00f3005a);
		rd(pa(2, OFS_RISE_STAT));
		chk(rdv, 32'hf3);
		wr(pa(2, OFS_RISE_MASK), 32'h0);
		wr(pa(2, OFS_RISE_STAT), 32'hff);
		wr(pa(2, OFS_FALL_STAT), 32'hff);
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic t_match;
		wr(pa(3, OFS_MATCH_REF), 32'h5a);
		wr(pa(3, OFS_MATCH_EN), 32'h1);
		chk({31'h0, irq}, 32'h0);
		drv(32'h5af3005a);
		chk({31'h0, irq}, 32'h1);
		rd(REG_STATUS);
		chk(rdv, 32'h8);
		drv(32'h00f3005a);
		wr(REG_STATUS, 32'h8);
		chk({31'h0, irq}, 32'h0);
		wr(pa(3, OFS_MATCH_EN), 32'h0);
	endtask
	// Fill from port b until the buffer refuses, read it while streaming, then stop.
	task automatic t_stream;
		drv(32'h00f33c5a);
		wr(REG_STREAM, 32'h3);
		rdv = 32'h0;
		for (int i = 0; i < 60 && {rdv[7], rdv[3:0]} !== 5'h08; i++) rd(REG_FIFO_STAT);
		chk({rdv[7], rdv[3:0]}, 32'h08);
		repeat (16) @(posedge sys_clk);
		rd(REG_FIFO_STAT);
		chk({rdv[7], rdv[3:0]}, 32'h08);
		for (int i = 0; i < 8; i++) begin
			rd(REG_STREAM);
			chk(rdv, 32'h13c);
		end
		wr(REG_FIFO_STAT, 32'h0);
		repeat (12) @(posedge sys_clk);
		rd(REG_FIFO_STAT);
		chk({rdv[7], rdv[3:0]}, 32'h10);
		rd(REG_STREAM);
		chk({31'h0, rdv[8]}, 32'h0);
	endtask
	// Stream two words out of port c, one per pace tick, then stop.
	task automatic t_stream_out;
		wr(REG_DIR, 32'h4);
		wr(REG_STREAM, 32'h5);
		wr(REG_STREAM, 32'h11);
		repeat (6) @(posedge sys_clk);
		#1;
		chk({24'h0, outs[23:16]}, 32'h11);
		wr(REG_STREAM, 32'h22);
		repeat (6) @(posedge sys_clk);
		#1;
		chk({24'h0, outs[23:16]}, 32'h22);
		rd(pa(2, OFS_DATA));
		chk(rdv, 32'h22);
		wr(REG_FIFO_STAT, 32'h0);
		wr(REG_DIR, 32'h0);
		drv(32'h00f33c5a);
		chk({31'h0, irq}, 32'h0);
	endtask
	// Main sequence: reset for ten cycles, then every scenario in turn.
	initial begin
		repeat (10) @(posedge sys_clk);
		nrst <= 1'b1;
		@(posedge sys_clk);
		#1;
		t_reset();
		t_dir();
		t_out();
		t_edge();
		t_match();
		t_stream();
		t_stream_out();
		wrap_up();
	end
	// Hang guard: a run this long counts as a mismatch.
	initial begin
		#100000;
		miscompares++;
		wrap_up();
	end
endmodule // bdp_port_tb
